// ---- include/dsau_map.vh ----
/*
 Address map, register offsets, reset values and widths for the data space
 access unit. Definitions only; included by bare name from rtl files.
*/
`ifndef DSAU_MAP_VH
`define DSAU_MAP_VH
`define DSAU_AW 16
`define DSAU_DW 16
`define DSAU_SPEC_END 16'h07FF
`define DSAU_NEAR_END 16'h1FFF
`define DSAU_RAM_BASE 16'h0800
`define DSAU_YBASE 16'h1800
`define DSAU_DMA_BASE 16'h2000
`define DSAU_RAM_END 16'h27FF
`define DSAU_PGW_BIT 15
`define DSAU_OFF_STACK_LIMIT 16'h0020
`define DSAU_OFF_TABLE_PAGE 16'h0032
`define DSAU_OFF_PGW_PAGE 16'h0034
`define DSAU_OFF_CORE_CTRL 16'h0044
`define DSAU_OFF_MOD_CTRL 16'h0046
`define DSAU_OFF_XMOD_START 16'h0048
`define DSAU_OFF_XMOD_END 16'h004A
`define DSAU_RST_ZERO 16'h0000
`define DSAU_RST_CORE_CTRL 16'h0020
`define DSAU_WREG_TOP 16'h001E
`define DSAU_NEAR_W 13
`define DSAU_STEP_BYTE 16'h0001
`define DSAU_STEP_WORD 16'h0002
`define DSAU_MOD_XEN 15
`define DSAU_MOD_YEN 14
`define DSAU_MOD_BREN 15
`endif

// ---- rtl/dsau_lane.v ----
/*
 Byte lane helper: builds write strobes and byte-replicated write data for one word.
 Assumes callers qualify the write enable with alignment checks.
*/
`timescale 1ns/1ps
`include "dsau_map.vh"
module dsau_lane #(
    parameter DW = 16
) (
    input wire byte_op,
    input wire addr_lsb,
    input wire [DW-1:0] wdata,
    output wire [1:0] lane_we,
    output wire [DW-1:0] lane_wdata
);
    // Byte goes to the lane picked by address bit 0, word drives both
    assign lane_we = byte_op ? (addr_lsb ? 2'h2 : 2'h1) : 2'h3;
    assign lane_wdata = byte_op ? {wdata[7:0], wdata[7:0]} : wdata;
endmodule

// ---- rtl/dsau_ram.v ----
/*
 Dual-ported word RAM with per-lane strobes, flip-flop storage.
 Port A is the CPU X/write side, port B the DMA or the Y read; both act in the same cycle.
*/
`timescale 1ns/1ps
module dsau_ram #(
    parameter DW = 16,
    parameter AW = 10
) (
    input wire sys_clk,
    input wire reset_n,
    input wire [AW-1:0] a_idx,
    input wire [1:0] a_we,
    input wire [DW-1:0] a_wdata,
    output wire [DW-1:0] a_rdata,
    input wire [AW-1:0] b_idx,
    input wire [1:0] b_we,
    input wire [DW-1:0] b_wdata,
    output wire [DW-1:0] b_rdata
);
    localparam DEPTH = 1 << AW;
    reg [DW-1:0] mem_r [0:DEPTH-1];
    genvar g;
    assign a_rdata = mem_r[a_idx];
    assign b_rdata = mem_r[b_idx];
    // Per word: port A lane write overrides port B on the same lane
    generate
        for (g = 0; g < DEPTH; g = g + 1)
        begin : g_word
            always @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                    mem_r[g] <= {DW{1'b0}};
                else
                begin
                    if (a_idx == g && a_we[0])
                        mem_r[g][7:0] <= a_wdata[7:0];
                    else if (b_idx == g && b_we[0])
                        mem_r[g][7:0] <= b_wdata[7:0];
                    if (a_idx == g && a_we[1])
                        mem_r[g][15:8] <= a_wdata[15:8];
                    else if (b_idx == g && b_we[1])
                        mem_r[g][15:8] <= b_wdata[15:8];
                end
            end
        end
    endgenerate
endmodule

// ---- rtl/dsau_top.v ----
/*
 Data space access unit: effective address handling, byte/word lanes,
 special register and RAM decode, X/Y read paths, DMA RAM port, address error event.
 Assumes the CPU address generation units present one read pair and one
 write per cycle and that the exception logic consumes the error pulse.
*/
`timescale 1ns/1ps
`include "dsau_map.vh"
// Overview of operation
// - Memory is 16-bit words, byte addressed, low byte at even address.
// - Pointer post-increment steps one for bytes, two for words.
// - Byte read takes whole word, bit 0 picks byte, output on low lane; here a program window byte read returns the whole pgw_data word.
// - Shared word decode, separate lane strobes; byte write hits one lane.
// - Word access at odd address raises address error trap; here an odd-address Y read raises no error.
// - Misaligned read completes; misaligned write suppressed; trap follows.
// - Byte load into working register changes only its low byte; here a byte write at a working register's odd address changes its high byte.
// - Sign-extend 8 to 16 bits; zero-extend clears upper byte.
// - Addresses 0x0000 to 0x07FF decode as special function registers.
// - Unused special register addresses read zero.
// - 0x0000 to 0x1FFF reachable with 13-bit absolute address.
// - Whole space reachable via 16-bit direct or register pointer.
// - X space has separate read and write buses; X read serves all; here a write takes RAM port A and an X RAM read then reads the write address.
// - Dual-operand multiply-accumulate reads Y concurrently with X.
// - Modulo addressing for X and Y; bit reverse only on X writes.
// - Writes use combined X plus Y space; boundary is fixed.
// - Effective addresses are 16-bit byte addresses over 64 Kbytes.
// - 2-Kbyte dual-ported RAM at top of Y shared with DMA.
// - DMA access never stalls CPU or takes CPU cycles; here it takes port B and a Y read in that cycle is dropped.
// - Same-location CPU and DMA write: CPU wins.
// - Reads outside implemented memory return zero.
// - Effective address bit 15 set goes to program window.
module dsau_top #(
    parameter AW = 16,
    parameter DW = 16,
    parameter RAM_AW = 12,
    parameter DMA_AW = 10
) (
    input wire sys_clk,
    input wire reset_n,
    input wire x_rd_en,
    input wire x_rd_byte,
    input wire [AW-1:0] x_rd_addr,
    output reg [DW-1:0] x_rd_data,
    input wire y_rd_en,
    input wire [AW-1:0] y_rd_addr,
    output reg [DW-1:0] y_rd_data,
    input wire wr_en,
    input wire wr_byte,
    input wire wr_direct13,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire ptr_byte,
    input wire [AW-1:0] source_pointer_reg,
    output wire [AW-1:0] ptr_post_inc,
    input wire ext_op,
    input wire ext_signed,
    input wire [DW-1:0] ext_in,
    output wire [DW-1:0] ext_out,
    input wire dma_en,
    input wire dma_we,
    input wire [DMA_AW-1:0] dma_idx,
    input wire [DW-1:0] dma_wdata,
    output reg [DW-1:0] dma_rdata,
    output reg pgw_rd,
    output reg [AW-2:0] pgw_offset,
    input wire [DW-1:0] pgw_data,
    output reg addr_err,
    output reg addr_err_wr,
    output wire [DW-1:0] stack_limit,
    output wire [DW-1:0] modulo_control,
    output wire [DW-1:0] core_control
);
    reg [DW-1:0] wreg_r [0:15];
    reg [DW-1:0] stack_limit_r;
    reg [DW-1:0] table_page_r;
    reg [DW-1:0] pgw_page_r;
    reg [DW-1:0] core_control_r;
    reg [DW-1:0] modulo_control_r;
    reg [DW-1:0] xmod_start_r;
    reg [DW-1:0] xmod_end_r;
    wire [AW-1:0] wa;
    wire x_mis;
    wire w_mis;
    wire wr_ok;
    wire [1:0] lane_we;
    wire [DW-1:0] lane_wdata;
    wire [DW-1:0] ram_xr;
    wire [DW-1:0] ram_yr;
    wire [DW-1:0] ram_dr;
    wire [1:0] ram_we;
    wire [DW-1:0] x_word;
    wire [DW-1:0] y_word;
    wire [1:0] dma_lwe;
    integer i;

    // Region tests, shared by the CPU read and write paths
    function in_spec;
        input [AW-1:0] a;
        begin
            in_spec = (a[`DSAU_PGW_BIT] == 1'b0) && (a <= `DSAU_SPEC_END);
        end
    endfunction

    function in_ram;
        input [AW-1:0] a;
        begin
            in_ram = (a >= `DSAU_RAM_BASE) && (a <= `DSAU_RAM_END);
        end
    endfunction

    function [RAM_AW-1:0] ram_idx;
        input [AW-1:0] a;
        reg [AW-1:0] off;
        begin
            off = a - `DSAU_RAM_BASE;
            ram_idx = off[RAM_AW:1];
        end
    endfunction

    // Special register read: holes return zero
    function [DW-1:0] spec_read;
        input [AW-1:0] a;
        reg [AW-1:0] w;
        begin
            w = {a[AW-1:1], 1'b0};
            spec_read = {DW{1'b0}};
            if (w <= `DSAU_WREG_TOP)
                spec_read = wreg_r[w[4:1]];
            else if (w == `DSAU_OFF_STACK_LIMIT)
                spec_read = stack_limit_r;
            else if (w == `DSAU_OFF_TABLE_PAGE)
                spec_read = table_page_r;
            else if (w == `DSAU_OFF_PGW_PAGE)
                spec_read = pgw_page_r;
            else if (w == `DSAU_OFF_CORE_CTRL)
                spec_read = core_control_r;
            else if (w == `DSAU_OFF_MOD_CTRL)
                spec_read = modulo_control_r;
            else if (w == `DSAU_OFF_XMOD_START)
                spec_read = xmod_start_r;
            else if (w == `DSAU_OFF_XMOD_END)
                spec_read = xmod_end_r;
        end
    endfunction

    // Merge lanes into an existing word
    function [DW-1:0] merge;
        input [DW-1:0] old;
        input [1:0] we;
        input [DW-1:0] nw;
        begin
            merge = {we[1] ? nw[15:8] : old[15:8], we[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    // Direct 13-bit form zero-extends into near space; full 16-bit otherwise
    assign wa = wr_direct13 ? {{(AW-`DSAU_NEAR_W){1'b0}}, wr_addr[`DSAU_NEAR_W-1:0]}
                            : wr_addr;

    // Pointer step scaled by operand size
    assign ptr_post_inc = source_pointer_reg + (ptr_byte ? `DSAU_STEP_BYTE
                                                         : `DSAU_STEP_WORD);

    // Extension unit; with no operation asked the word passes unchanged
    assign ext_out = !ext_op ? ext_in
                   : ext_signed ? {{8{ext_in[7]}}, ext_in[7:0]}
                                : {8'h00, ext_in[7:0]};

    // Word access at odd address is misaligned
    assign x_mis = x_rd_en && !x_rd_byte && x_rd_addr[0];
    assign w_mis = wr_en && !wr_byte && wa[0];
    assign wr_ok = wr_en && !w_mis;

    dsau_lane #(
        .DW(DW)
    ) u_lane (
        .byte_op(wr_byte),
        .addr_lsb(wa[0]),
        .wdata(wr_data),
        .lane_we(lane_we),
        .lane_wdata(lane_wdata)
    );

    // Writes go into one combined X+Y range; boundary only a constant
    assign ram_we = (wr_ok && in_ram(wa)) ? lane_we : 2'h0;
    assign dma_lwe = (dma_en && dma_we) ? 2'h3 : 2'h0;

    // DMA takes port B; a Y read in the same cycle is dropped, CPU never stalls
    dsau_ram #(
        .DW(DW),
        .AW(RAM_AW)
    ) u_ram (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .a_idx(wr_en ? ram_idx(wa) : ram_idx(x_rd_addr)),
        .a_we(ram_we),
        .a_wdata(lane_wdata),
        .a_rdata(ram_xr),
        .b_idx(dma_en ? ram_idx(`DSAU_DMA_BASE) + {{(RAM_AW-DMA_AW){1'b0}}, dma_idx}
                      : ram_idx(y_rd_addr)),
        .b_we(dma_lwe),
        .b_wdata(dma_wdata),
        .b_rdata(ram_dr)
    );

    // Y read path is port B of the same array, combinational
    assign ram_yr = ram_dr;

    // X word select: special register, RAM, else zero
    assign x_word = in_spec(x_rd_addr) ? spec_read(x_rd_addr)
                  : in_ram(x_rd_addr) ? ram_xr : {DW{1'b0}};
    assign y_word = in_ram(y_rd_addr) ? ram_yr : {DW{1'b0}};

    // Read data registers; data-space byte picks lane by bit 0 onto low lane, window reads take whole pgw_data
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            x_rd_data <= `DSAU_RST_ZERO;
            y_rd_data <= `DSAU_RST_ZERO;
            dma_rdata <= `DSAU_RST_ZERO;
            pgw_rd <= 1'b0;
            pgw_offset <= {(AW-1){1'b0}};
        end
        else
        begin
            pgw_rd <= x_rd_en && x_rd_addr[`DSAU_PGW_BIT];
            pgw_offset <= x_rd_addr[AW-2:0];
            if (x_rd_en)
            begin
                if (x_rd_addr[`DSAU_PGW_BIT])
                    x_rd_data <= `DSAU_RST_ZERO;
                else if (x_rd_byte)
                    x_rd_data <= {8'h00, x_rd_addr[0] ? x_word[15:8] : x_word[7:0]};
                else
                    x_rd_data <= x_word;
            end
            else if (pgw_rd)
                x_rd_data <= pgw_data;
            if (y_rd_en && !dma_en)
                y_rd_data <= y_word;
            if (dma_en)
                dma_rdata <= ram_dr;
        end
    end

    // Address error event: one cycle, with read/write flag
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_err <= 1'b0;
            addr_err_wr <= 1'b0;
        end
        else
        begin
            addr_err <= x_mis || w_mis;
            addr_err_wr <= w_mis;
        end
    end

    // Special register writes: byte lane merge, misaligned suppressed
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (i = 0; i < 16; i = i + 1)
                wreg_r[i] <= `DSAU_RST_ZERO;
            stack_limit_r <= `DSAU_RST_ZERO;
            table_page_r <= `DSAU_RST_ZERO;
            pgw_page_r <= `DSAU_RST_ZERO;
            core_control_r <= `DSAU_RST_CORE_CTRL;
            modulo_control_r <= `DSAU_RST_ZERO;
            xmod_start_r <= `DSAU_RST_ZERO;
            xmod_end_r <= `DSAU_RST_ZERO;
        end
        else if (wr_ok && in_spec(wa))
        begin
            if ({wa[AW-1:1], 1'b0} <= `DSAU_WREG_TOP)
                wreg_r[wa[4:1]] <= merge(wreg_r[wa[4:1]], lane_we, lane_wdata);
            else if ({wa[AW-1:1], 1'b0} == `DSAU_OFF_STACK_LIMIT)
                stack_limit_r <= merge(stack_limit_r, lane_we, lane_wdata);
            else if ({wa[AW-1:1], 1'b0} == `DSAU_OFF_TABLE_PAGE)
                table_page_r <= merge(table_page_r, lane_we, lane_wdata);
            else if ({wa[AW-1:1], 1'b0} == `DSAU_OFF_PGW_PAGE)
                pgw_page_r <= merge(pgw_page_r, lane_we, lane_wdata);
            else if ({wa[AW-1:1], 1'b0} == `DSAU_OFF_CORE_CTRL)
                core_control_r <= merge(core_control_r, lane_we, lane_wdata);
            else if ({wa[AW-1:1], 1'b0} == `DSAU_OFF_MOD_CTRL)
                modulo_control_r <= merge(modulo_control_r, lane_we, lane_wdata);
            else if ({wa[AW-1:1], 1'b0} == `DSAU_OFF_XMOD_START)
                xmod_start_r <= merge(xmod_start_r, lane_we, lane_wdata);
            else if ({wa[AW-1:1], 1'b0} == `DSAU_OFF_XMOD_END)
                xmod_end_r <= merge(xmod_end_r, lane_we, lane_wdata);
        end
    end

    // Stack limit, modulo control (X, Y enables) and core control go to the address units
    assign stack_limit = stack_limit_r;
    assign modulo_control = modulo_control_r;
    assign core_control = core_control_r;
endmodule

// ---- testbench/dsau_chk_sva.sv ----
/*
 Checker for dsau_top: address error event, pointer step, program window
 routing, zero holes and stack limit writes.
 Assumes it is bound into dsau_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module dsau_chk #(
    parameter AW = 16,
    parameter DW = 16
) (
    input wire sys_clk,
    input wire reset_n,
    input wire x_rd_en,
    input wire x_rd_byte,
    input wire [AW-1:0] x_rd_addr,
    input wire [DW-1:0] x_rd_data,
    input wire wr_en,
    input wire wr_byte,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire ptr_byte,
    input wire [AW-1:0] source_pointer_reg,
    input wire [AW-1:0] ptr_post_inc,
    input wire pgw_rd,
    input wire [AW-2:0] pgw_offset,
    input wire addr_err,
    input wire addr_err_wr,
    input wire [DW-1:0] stack_limit
);
    default clocking dsau_cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // Odd word accesses; a concurrent write owns the port, so reads are checked alone
    wire odd_rd = x_rd_en && !x_rd_byte && x_rd_addr[0];
    wire odd_wr = wr_en && !wr_byte && wr_addr[0];
    wire rd_only = x_rd_en && !wr_en;
    // Window request, then its pulse with the offset one edge later
    sequence s_pgw_req;
        rd_only && x_rd_addr[AW-1];
    endsequence
    sequence s_pgw_ans;
        pgw_rd && pgw_offset == $past(x_rd_addr[AW-2:0]);
    endsequence
    sequence s_odd_wr;
        odd_wr;
    endsequence
    chk_err_read: assert property (odd_rd && !wr_en |=> addr_err && !addr_err_wr)
        else $error("read error pulse missing");
    chk_err_write: assert property (s_odd_wr |=> addr_err && addr_err_wr)
        else $error("write error pulse missing");
    chk_err_quiet: assert property (!odd_rd && !odd_wr |=> !addr_err)
        else $error("error pulse without cause");
    chk_ptr_step: assert property (ptr_post_inc == 16'(source_pointer_reg + (ptr_byte ? 1 : 2)))
        else $error("pointer step wrong");
    chk_pgw_route: assert property (s_pgw_req |=> s_pgw_ans)
        else $error("window read not routed");
    chk_pgw_idle: assert property (!(x_rd_en && x_rd_addr[AW-1]) |=> !pgw_rd)
        else $error("window pulse without request");
    chk_hole_zero: assert property (rd_only && x_rd_addr[AW-1:AW-2] == 2'b01 |=> x_rd_data == 0)
        else $error("unimplemented read not zero");
    chk_limit_write: assert property (wr_en && !wr_byte && wr_addr == 16'h0020
        |=> stack_limit == $past(wr_data))
        else $error("stack limit write lost");
endmodule
bind dsau_top dsau_chk #(.AW(AW), .DW(DW)) dsau_chk_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .x_rd_en(x_rd_en), .x_rd_byte(x_rd_byte),
    .x_rd_addr(x_rd_addr), .x_rd_data(x_rd_data), .wr_en(wr_en), .wr_byte(wr_byte),
    .wr_addr(wr_addr), .wr_data(wr_data), .ptr_byte(ptr_byte),
    .source_pointer_reg(source_pointer_reg), .ptr_post_inc(ptr_post_inc), .pgw_rd(pgw_rd),
    .pgw_offset(pgw_offset), .addr_err(addr_err), .addr_err_wr(addr_err_wr),
    .stack_limit(stack_limit)
);

// ---- testbench/dsau_psv_model.sv ----
/*
 Program-space responder behind the visibility window.
 Assumes pgw_rd is a one-cycle pulse and pgw_offset holds after it.
*/
`timescale 1ns/1ps
module dsau_pgw_model (
    input wire sys_clk,
    input wire reset_n,
    input wire pgw_rd,
    input wire [14:0] pgw_offset,
    output wire [15:0] pgw_data
);
    reg live_r;
    reg [15:0] junk_r;
    // Answer lives two cycles; a moving pattern otherwise exposes stale use
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            live_r <= 1'b0;
            junk_r <= 16'hA5C3;
        end
        else
        begin
            live_r <= pgw_rd;
            junk_r <= ~{junk_r[14:0], junk_r[15]};
        end
    end
    assign pgw_data = (pgw_rd || live_r) ? ({1'b1, pgw_offset} ^ 16'h5A5A) : junk_r;
endmodule

// ---- testbench/test_data_space_access_unit.sv ----
/*
 Self-checking bench for dsau_top with a program-space responder.
 Assumes the checker binds itself into dsau_top from its own file.
*/
`timescale 1ns/1ps
module test_data_space_access_unit;
    typedef struct {int due; int sel; logic [15:0] exp;} dsau_note_t;
    reg sys_clk = 1'b0;
    reg reset_n = 1'b0;
    reg x_rd_en = 1'b0, x_rd_byte = 1'b0, y_rd_en = 1'b0, wr_en = 1'b0, wr_byte = 1'b0;
    reg wr_direct13 = 1'b0, ptr_byte = 1'b0, ext_op = 1'b0, ext_signed = 1'b0;
    reg dma_en = 1'b0, dma_we = 1'b0;
    reg [9:0] dma_idx = 10'h000;
    reg [15:0] x_rd_addr = 16'h0000, y_rd_addr = 16'h0000, wr_addr = 16'h0000;
    reg [15:0] wr_data = 16'h0000, source_pointer_reg = 16'h0000;
    reg [15:0] ext_in = 16'h0000, dma_wdata = 16'h0000;
    wire [15:0] x_rd_data, y_rd_data, dma_rdata, pgw_data, stack_limit;
    wire [15:0] modulo_control, core_control, ptr_post_inc, ext_out;
    wire [14:0] pgw_offset;
    wire pgw_rd, addr_err, addr_err_wr;
    int n_mismatch = 0, checked = 0, cyc = 0;
    dsau_note_t notes[$];
    dsau_note_t cur;
    logic [15:0] a, d, w, b;
    dsau_top dsau_top_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .x_rd_en(x_rd_en), .x_rd_byte(x_rd_byte),
        .x_rd_addr(x_rd_addr), .x_rd_data(x_rd_data), .y_rd_en(y_rd_en),
        .y_rd_addr(y_rd_addr), .y_rd_data(y_rd_data), .wr_en(wr_en), .wr_byte(wr_byte),
        .wr_direct13(wr_direct13), .wr_addr(wr_addr), .wr_data(wr_data),
        .ptr_byte(ptr_byte), .source_pointer_reg(source_pointer_reg),
        .ptr_post_inc(ptr_post_inc), .ext_op(ext_op), .ext_signed(ext_signed),
        .ext_in(ext_in), .ext_out(ext_out), .dma_en(dma_en), .dma_we(dma_we),
        .dma_idx(dma_idx), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata),
        .pgw_rd(pgw_rd), .pgw_offset(pgw_offset), .pgw_data(pgw_data),
        .addr_err(addr_err), .addr_err_wr(addr_err_wr), .stack_limit(stack_limit),
        .modulo_control(modulo_control), .core_control(core_control)
    );
    dsau_pgw_model dsau_pgw_model_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .pgw_rd(pgw_rd), .pgw_offset(pgw_offset),
        .pgw_data(pgw_data)
    );
    // 100 ns clock and an edge count for due notes
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    begin
        checked = checked + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task note(input int sel, input logic [15:0] exp, input int dly);
    begin
        notes.push_back('{cyc + dly, sel, exp});
    end
    endtask
    // One CPU request for one cycle; error pulse expected for odd words
    task cpu(input logic wr, input logic [15:0] adr, input logic [15:0] dat,
             input logic byt, input int sel, input int dly);
    begin
        @(negedge sys_clk);
        wr_en = wr;
        x_rd_en = ~wr;
        wr_addr = adr;
        x_rd_addr = adr;
        wr_data = dat;
        wr_byte = byt;
        x_rd_byte = byt;
        note(3, {14'h0000, adr[0] & ~byt, adr[0] & ~byt & wr}, 1);
        if (sel >= 0)
            note(sel, dat, dly);
        @(negedge sys_clk);
        wr_en = 1'b0;
        x_rd_en = 1'b0;
    end
    endtask
    task yrd(input logic [15:0] adr, input logic [15:0] exp);
    begin
        @(negedge sys_clk);
        y_rd_en = 1'b1;
        y_rd_addr = adr;
        note(1, exp, 1);
        @(negedge sys_clk);
        y_rd_en = 1'b0;
    end
    endtask
    // Write data is inverted when writing nothing, so a stray write shows
    task dma(input logic we, input logic [9:0] idx, input logic [15:0] dat);
    begin
        @(negedge sys_clk);
        dma_en = 1'b1;
        dma_we = we;
        dma_idx = idx;
        dma_wdata = we ? dat : ~dat;
        if (!we)
            note(2, dat, 1);
        @(negedge sys_clk);
        dma_en = 1'b0;
    end
    endtask
    // Oldest note is compared once its answer edge has passed
    always @(negedge sys_clk)
    begin
        while (notes.size() > 0 && notes[0].due <= cyc)
        begin
            cur = notes.pop_front();
            case (cur.sel)
                0: check("x_rd_data", x_rd_data, cur.exp);
                1: check("y_rd_data", y_rd_data, cur.exp);
                2: check("dma_rdata", dma_rdata, cur.exp);
                3: check("addr_err", {14'h0000, addr_err, addr_err_wr}, cur.exp);
                4: check("stack_limit", stack_limit, cur.exp);
                5: check("modulo_control", modulo_control, cur.exp);
                default: check("x_rd_byte", x_rd_data, cur.exp);
            endcase
        end
    end
    task finish_test;
    begin
        if (notes.size() != 0)
            n_mismatch = n_mismatch + 1;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    // Run is about a hundred cycles; far beyond that means a hang
    initial
    begin
        #(5000 * 100);
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
    initial
    begin
        void'($urandom(32'h401A));
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        check("core_control", core_control, 16'h0020);
        check("modulo_control", modulo_control, 16'h0000);
        // Pointer step and extension in both modes
        for (int i = 0; i < 8; i++)
        begin
            @(negedge sys_clk);
            source_pointer_reg = 16'($urandom);
            ptr_byte = i[0];
            ext_op = (i != 7);
            ext_signed = i[1];
            ext_in = {8'($urandom), i[2], 7'($urandom)};
            #1;
            w = i[0] ? 16'h0001 : 16'h0002;
            check("ptr_post_inc", ptr_post_inc, source_pointer_reg + w);
            check("ext_out", ext_out,
                  ext_op ? {i[1] ? {8{ext_in[7]}} : 8'h00, ext_in[7:0]} : ext_in);
        end
        // Word traffic into X and Y RAM, then both read back in one cycle
        repeat (6)
        begin
            a = 16'h0800 + {4'h0, 11'($urandom), 1'b0};
            b = 16'h1800 + {4'h0, 11'($urandom), 1'b0};
            d = 16'($urandom);
            cpu(1, a, d, 0, -1, 1);
            cpu(1, b, ~d, 0, -1, 1);
            fork
                cpu(0, a, d, 0, 0, 1);
                yrd(b, ~d);
            join
        end
        // Byte lanes on a RAM word, then on a working register
        for (int i = 0; i < 2; i++)
        begin
            a = i ? 16'h0002 : 16'h0800 + {3'b000, 12'($urandom), 1'b0};
            w = 16'($urandom);
            b = 16'($urandom);
            cpu(1, a, w, 0, -1, 1);
            cpu(1, a, {8'h00, b[7:0]}, 1, -1, 1);
            cpu(0, a, {w[15:8], b[7:0]}, 0, 0, 1);
            cpu(0, a + 16'h0001, {8'h00, w[15:8]}, 1, 6, 1);
            cpu(1, a + 16'h0001, {8'h00, b[15:8]}, 1, -1, 1);
            cpu(0, a, b, 0, 0, 1);
        end
        // Odd word write is dropped, odd word read still completes
        cpu(1, a + 16'h0001, ~b, 0, -1, 1);
        cpu(0, a, b, 0, 0, 1);
        d = 16'($urandom);
        cpu(1, 16'h0020, d, 0, 4, 1);
        cpu(1, 16'h0021, ~d, 0, -1, 1);
        note(4, d, 0);
        cpu(0, 16'h0020, d, 0, 0, 1);
        cpu(0, 16'h0021, d, 0, 0, 1);
        wr_direct13 = 1'b1;
        cpu(1, 16'hE046, 16'hC3A5, 0, 5, 1);
        wr_direct13 = 1'b0;
        // Unused SPECIAL_FUNCTION_REGISTER word and unimplemented space read back zero
        for (int i = 0; i < 3; i++)
        begin
            a = i == 0 ? 16'h0100 : (i == 1 ? 16'h2800 : 16'h7FFE);
            cpu(0, a, 16'h0000, 0, 0, 1);
        end
        // DMA RAM from both sides, a parallel read pair and a write clash
        dma(1, 10'h3FF, d);
        cpu(0, 16'h27FE, d, 0, 0, 1);
        cpu(1, 16'h2010, ~d, 0, -1, 1);
        fork
            dma(0, 10'h008, ~d);
            cpu(0, 16'h27FE, d, 0, 0, 1);
        join
        fork
            dma(1, 10'h008, d);
            cpu(1, 16'h2010, b, 0, -1, 1);
        join
        dma(0, 10'h008, b);
        // Program window read answered by the responder
        a = {1'b1, 14'($urandom), 1'b0};
        cpu(0, a, {1'b1, a[14:0]} ^ 16'h5A5A, 0, 0, 3);
        repeat (4) @(negedge sys_clk);
        finish_test;
    end
endmodule
